/* File: hdl/seecp_regs.svh */
`ifndef SEECP_REGS_SVH
`define SEECP_REGS_SVH
// opcode field values (two bits after the start bit)
`define SEECP_OP_EXT      2'h0
`define SEECP_OP_WRITE    2'h1
`define SEECP_OP_READ     2'h2
`define SEECP_OP_ERASE    2'h3
// qualifier bits of the extended opcode
`define SEECP_EXT_DIS     2'h0
`define SEECP_EXT_WRITE_ALL_CMD    2'h1
`define SEECP_EXT_ERASE_ALL_CMD    2'h2
`define SEECP_EXT_EN      2'h3
// clocks after the start bit: opcode + address (+ data)
`define SEECP_LEN_CMD16   6'h0A
`define SEECP_LEN_DAT16   6'h1A
`define SEECP_LEN_CMD8    6'h0B
`define SEECP_LEN_DAT8    6'h13
// cycle times in microseconds
`define SEECP_TWC_LV_US   6000
`define SEECP_TWC_HV_US   2000
`define SEECP_TEC_US      6000
`define SEECP_TWL_US      15000
`define SEECP_CLK_MHZ     100
`define SEECP_ERASED_BYTE 8'hFF
`endif

/* File: hdl/seecp_pkg.sv */
package seecp_pkg;
   // programming job kinds
   typedef enum logic [1:0] {
      SEECP_JOB_ERASE = 2'b00,
      SEECP_JOB_WRITE = 2'b01,
      SEECP_JOB_ERASE_ALL_CMD  = 2'b10,
      SEECP_JOB_WRITE_ALL_CMD  = 2'b11
   } seecp_job_t;
   // one programming request
   typedef struct packed {
      seecp_job_t  job;
      logic [7:0]  addr;
      logic [15:0] data;
      logic        wide;
   } seecp_req_t;
   // synchronised serial pins
   typedef struct packed {
      logic sel;
      logic sclk;
      logic sdi;
   } seecp_pins_t;
endpackage

/* File: hdl/seecp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module seecp_sync
#(
   parameter int WIDTH = 3
)
(
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   // two flop synchroniser per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         always_ff @(posedge clk_in or negedge rstn_in)
         begin
            if (!rstn_in)
            begin
               meta_r[i] <= 1'b0;
               sync_r[i] <= 1'b0;
            end
            else
            begin
               meta_r[i] <= async_in[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate
   assign sync_out = sync_r;
endmodule
`default_nettype wire

/* File: hdl/seecp_prog.sv */
`timescale 1ns/1ps
`include "seecp_regs.svh"
`default_nettype none
// self-timed programming engine; owns the memory array
module seecp_prog
#(
   parameter int TWC_CYC = `SEECP_TWC_LV_US * `SEECP_CLK_MHZ,
   parameter int TEC_CYC = `SEECP_TEC_US * `SEECP_CLK_MHZ,
   parameter int TWL_CYC = `SEECP_TWL_US * `SEECP_CLK_MHZ
)
(
   input  wire logic                   clk_in,
   input  wire logic                   rstn_in,
   input  wire logic                   start_in,
   input  wire seecp_pkg::seecp_req_t  req_in,
   input  wire logic [7:0]             rd_addr_in,
   output logic      [7:0]             rd_byte_out,
   output logic      [7:0]             rd_hi_byte_out,
   output logic                        busy_out
);
   logic [7:0]              mem_r [0:255];
   logic [31:0]             cnt_r;
   logic                    busy_r;
   seecp_pkg::seecp_req_t   req_r;
   logic [31:0]             len;
   logic                    done;
   logic [7:0]              lo_addr;
   logic [7:0]              hi_addr;
   // cycle budget per job kind
   assign len = (req_in.job == seecp_pkg::SEECP_JOB_ERASE_ALL_CMD) ? TEC_CYC[31:0] :
                (req_in.job == seecp_pkg::SEECP_JOB_WRITE_ALL_CMD) ? TWL_CYC[31:0] : TWC_CYC[31:0];
   assign done = busy_r && (cnt_r == 32'h1);
   assign lo_addr = req_r.wide ? {req_r.addr[6:0], 1'b0} : req_r.addr;
   assign hi_addr = {req_r.addr[6:0], 1'b1};
   // timer; runs to the end regardless of select
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         busy_r <= 1'b0;
         cnt_r  <= 32'h0;
         req_r  <= '0;
      end
      else if (start_in && !busy_r)
      begin
         busy_r <= 1'b1;
         cnt_r  <= len;
         req_r  <= req_in;
      end
      else if (busy_r)
      begin
         cnt_r  <= cnt_r - 32'h1;
         busy_r <= !done;
      end
   end
   // array update at the end of the cycle
   always_ff @(posedge clk_in)
   begin
      if (done)
      begin
         for (int k = 0; k < 256; k++)
         begin
            if (req_r.job == seecp_pkg::SEECP_JOB_ERASE_ALL_CMD)
               mem_r[k] <= `SEECP_ERASED_BYTE;
            else if (req_r.job == seecp_pkg::SEECP_JOB_WRITE_ALL_CMD)
               mem_r[k] <= (req_r.wide && k[0]) ? req_r.data[15:8] : req_r.data[7:0];
         end
         if (req_r.job == seecp_pkg::SEECP_JOB_ERASE)
         begin
            mem_r[lo_addr] <= `SEECP_ERASED_BYTE;
            if (req_r.wide)
               mem_r[hi_addr] <= `SEECP_ERASED_BYTE;
         end
         else if (req_r.job == seecp_pkg::SEECP_JOB_WRITE)
         begin
            mem_r[lo_addr] <= req_r.data[7:0];
            if (req_r.wide)
               mem_r[hi_addr] <= req_r.data[15:8];
         end
      end
   end
   assign rd_byte_out = mem_r[rd_addr_in];
   // odd byte of the word pair, for 16-bit reads
   assign rd_hi_byte_out = mem_r[{rd_addr_in[7:1], 1'b1}];
   assign busy_out = busy_r;
endmodule
`default_nettype wire

/* File: hdl/seecp_port.sv */
// How it works
// - strap high selects 16-bit words, low 8-bit
// - input bits sampled on serial clock rise
// - output released except read or status
// - status low while busy, high when ready
// - output released on select fall
// - start bit: first rise with select, input high
// - nothing happens before a start bit
// - standby left when select rises
// - short sequences are discarded
// - opcode and qualifier decode
// - 16-bit: 11 or 27 clocks
// - 8-bit: 12 or 20 clocks
// - read gives data, programming gives status
// - single location cycle 6 ms or 2 ms
// - erase all 6 ms, write all 15 ms
// - programming disabled until enable command
// - read: dummy zero, then sequential words
// - cycle start: select fall or last clock
// - select low resets control, cycle completes
`timescale 1ns/1ps
`include "seecp_regs.svh"
`default_nettype none
module seecp_port
#(
   parameter bit HV_VARIANT = 1'b0,
   parameter int TWC_CYC    = (HV_VARIANT ? `SEECP_TWC_HV_US : `SEECP_TWC_LV_US) * `SEECP_CLK_MHZ,
   parameter int TEC_CYC    = `SEECP_TEC_US * `SEECP_CLK_MHZ,
   parameter int TWL_CYC    = `SEECP_TWL_US * `SEECP_CLK_MHZ
)
(
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic chip_select_in,
   input  wire logic serial_clk_in,
   input  wire logic serial_in_pin_in,
   input  wire logic word_size_strap_in,
   output logic      serial_out_out,
   output logic      serial_out_oe_out,
   output logic      prog_busy_out
);
   typedef enum logic [2:0] {
      SEECP_IDLE = 3'b000,
      SEECP_SHIFT = 3'b001,
      SEECP_READ = 3'b010,
      SEECP_ARMED = 3'b011,
      SEECP_STATUS = 3'b100,
      SEECP_DONE = 3'b101
   } seecp_state_t;

   seecp_pkg::seecp_pins_t pins;
   seecp_pkg::seecp_req_t  req;
   seecp_state_t           state_r;
   seecp_state_t           state_nxt;
   logic                   sclk_d_r;
   logic                   sel_d_r;
   logic                   strap_meta_r;
   logic                   strap_r;
   logic [5:0]             cmd_len;
   logic [26:0]            hdr;
   logic                   prog_en_r;
   logic [5:0]             bits_r;
   logic [26:0]            shift_r;
   logic [16:0]            rd_shift_r;
   logic [4:0]             rd_cnt_r;
   logic [7:0]             rd_addr_r;
   logic                   do_r;
   logic                   oe_r;
   logic                   pend_r;
   logic                   rise;
   logic                   sel_fall;
   logic                   wide;
   logic [5:0]             need;
   logic [1:0]             op;
   logic [1:0]             ext;
   logic [7:0]             addr;
   logic [15:0]            wdata;
   logic                   is_data;
   logic                   complete;
   logic                   is_prog;
   logic                   prog_start;
   logic                   busy;
   logic [7:0]             rd_byte;
   logic [7:0]             rd_byte_hi;
   logic [7:0]             fetch_addr;
   logic [4:0]             word_bits;

   // pins cross into the clock domain first
   seecp_sync #(.WIDTH(3)) u_sync
   (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .async_in ({chip_select_in, serial_clk_in, serial_in_pin_in}),
      .sync_out (pins)
   );

   // edge detection on the synchronised pins
   assign rise     = pins.sel && pins.sclk && !sclk_d_r;
   assign sel_fall = sel_d_r && !pins.sel;
   assign wide     = strap_r;
   assign word_bits = wide ? 5'h10 : 5'h08;

   // field decode; once data bits arrive the header sits one word higher
   assign cmd_len = wide ? `SEECP_LEN_CMD16 : `SEECP_LEN_CMD8;
   assign hdr     = (bits_r > cmd_len) ? (shift_r >> word_bits) : shift_r;
   assign op      = wide ? hdr[9:8] : hdr[10:9];
   assign ext     = wide ? hdr[7:6] : hdr[8:7];
   assign addr    = wide ? {1'b0, hdr[6:0]} : hdr[7:0];
   assign wdata   = wide ? shift_r[15:0] : {8'h00, shift_r[7:0]};
   assign is_data = (bits_r > cmd_len) ||
                    (op == `SEECP_OP_READ) || (op == `SEECP_OP_WRITE) ||
                    (op == `SEECP_OP_EXT && ext == `SEECP_EXT_WRITE_ALL_CMD);
   assign need    = wide ? ((op == `SEECP_OP_READ) ? `SEECP_LEN_CMD16 :
                            (is_data ? `SEECP_LEN_DAT16 : `SEECP_LEN_CMD16)) :
                           ((op == `SEECP_OP_READ) ? `SEECP_LEN_CMD8 :
                            (is_data ? `SEECP_LEN_DAT8 : `SEECP_LEN_CMD8));
   assign complete = (bits_r == need);
   assign is_prog  = (op == `SEECP_OP_WRITE) || (op == `SEECP_OP_ERASE) ||
                     (op == `SEECP_OP_EXT && (ext == `SEECP_EXT_WRITE_ALL_CMD || ext == `SEECP_EXT_ERASE_ALL_CMD));

   // programming request record
   assign req.job  = (op == `SEECP_OP_ERASE) ? seecp_pkg::SEECP_JOB_ERASE :
                     (op == `SEECP_OP_WRITE) ? seecp_pkg::SEECP_JOB_WRITE :
                     (ext == `SEECP_EXT_ERASE_ALL_CMD) ? seecp_pkg::SEECP_JOB_ERASE_ALL_CMD :
                     seecp_pkg::SEECP_JOB_WRITE_ALL_CMD;
   assign req.addr = addr;
   assign req.data = wdata;
   assign req.wide = wide;
   // cycle starts on select fall, or at the last clock on the fast variant
   assign prog_start = prog_en_r && !busy &&
                       ((state_r == SEECP_ARMED && sel_fall && !HV_VARIANT) ||
                        (state_r == SEECP_SHIFT && rise && HV_VARIANT && is_prog &&
                         (bits_r + 6'h01 == need) && op != `SEECP_OP_READ));

   // memory reads: low byte, and high byte for wide words
   assign fetch_addr = wide ? {rd_addr_r[6:0], 1'b0} : rd_addr_r;

   seecp_prog #(.TWC_CYC(TWC_CYC), .TEC_CYC(TEC_CYC), .TWL_CYC(TWL_CYC)) u_prog
   (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .start_in    (prog_start),
      .req_in      (req),
      .rd_addr_in  (fetch_addr),
      .rd_byte_out (rd_byte),
      .rd_hi_byte_out (rd_byte_hi),
      .busy_out    (busy)
   );

   // next state of the command sequencer
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         SEECP_IDLE:
            if (rise && pins.sdi)
               state_nxt = SEECP_SHIFT;
         SEECP_SHIFT:
            if (complete)
               state_nxt = (op == `SEECP_OP_READ) ? SEECP_READ :
                           (is_prog ? SEECP_ARMED : SEECP_DONE);
         SEECP_READ:
            state_nxt = SEECP_READ;
         SEECP_ARMED:
            state_nxt = SEECP_ARMED;
         SEECP_STATUS:
            state_nxt = SEECP_STATUS;
         SEECP_DONE:
            state_nxt = SEECP_DONE;
         default:
            state_nxt = SEECP_IDLE;
      endcase
      if (!pins.sel)
         state_nxt = SEECP_IDLE;
   end

   // strap pin passes two flops; the second only loads while idle
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         strap_meta_r <= 1'b0;
         strap_r      <= 1'b0;
      end
      else
      begin
         strap_meta_r <= word_size_strap_in;
         if (state_r == SEECP_IDLE)
            strap_r <= strap_meta_r;
      end
   end

   // sequencer, shifter and enable latch
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_r   <= SEECP_IDLE;
         sclk_d_r  <= 1'b0;
         sel_d_r   <= 1'b0;
         bits_r    <= 6'h00;
         shift_r   <= 27'h0;
         prog_en_r <= 1'b0;
      end
      else
      begin
         state_r  <= state_nxt;
         sclk_d_r <= pins.sclk;
         sel_d_r  <= pins.sel;
         if (!pins.sel || state_r == SEECP_IDLE)
         begin
            bits_r  <= 6'h00;
            shift_r <= 27'h0;
         end
         else if (state_r == SEECP_SHIFT && rise && !complete)
         begin
            bits_r  <= bits_r + 6'h01;
            shift_r <= {shift_r[25:0], pins.sdi};
         end
         if (state_r == SEECP_SHIFT && complete && op == `SEECP_OP_EXT)
         begin
            if (ext == `SEECP_EXT_EN)
               prog_en_r <= 1'b1;
            else if (ext == `SEECP_EXT_DIS)
               prog_en_r <= 1'b0;
         end
      end
   end

   // read shifter: dummy zero then words, address auto increments
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rd_shift_r <= 17'h0;
         rd_cnt_r   <= 5'h00;
         rd_addr_r  <= 8'h00;
         pend_r     <= 1'b0;
      end
      else if (state_r == SEECP_SHIFT && complete && op == `SEECP_OP_READ)
      begin
         rd_addr_r <= addr;
         pend_r    <= 1'b1;
         rd_cnt_r  <= 5'h00;
         rd_shift_r <= 17'h0;
      end
      else if (state_r == SEECP_READ && pend_r)
      begin
         pend_r    <= 1'b0;
         // dummy zero already stands on the pin; words follow msb first
         rd_shift_r <= wide ? {rd_byte_hi, rd_byte, 1'b0} : {rd_byte, 9'h000};
         rd_cnt_r  <= word_bits;
      end
      else if (state_r == SEECP_READ && rise)
      begin
         rd_shift_r <= {rd_shift_r[15:0], 1'b0};
         rd_cnt_r  <= rd_cnt_r - 5'h01;
         if (rd_cnt_r == 5'h01)
         begin
            rd_addr_r <= rd_addr_r + 8'h01;
            pend_r    <= 1'b1;
         end
      end
   end

   // output pin: data during read, status when reselected after programming
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         do_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else if (sel_fall || !pins.sel)
      begin
         oe_r <= 1'b0;
         do_r <= 1'b0;
      end
      else if (state_r == SEECP_READ)
      begin
         oe_r <= 1'b1;
         if (rise)
            do_r <= rd_shift_r[16];
      end
      else if (state_r == SEECP_IDLE && (busy || prog_start))
      begin
         oe_r <= 1'b1;
         do_r <= 1'b0;
      end
      else if (state_r == SEECP_IDLE && oe_r)
         do_r <= 1'b1;
      else if (state_r != SEECP_IDLE)
      begin
         oe_r <= 1'b0;
         do_r <= 1'b0;                                       // dummy zero of a read
      end
   end

   assign serial_out_out    = do_r;
   assign serial_out_oe_out = oe_r;
   assign prog_busy_out     = busy;
endmodule
`default_nettype wire

/* File: bench/seecp_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// pin-level checks of the serial command port
module seecp_sva
#(
   parameter int TWL_CYC = 1500000
)
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic chip_select_in,
   input wire logic serial_clk_in,
   input wire logic serial_in_pin_in,
   input wire logic word_size_strap_in,
   input wire logic serial_out_out,
   input wire logic serial_out_oe_out,
   input wire logic prog_busy_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   logic [31:0] busy_cnt_r;
   logic [3:0]  rise_age_r;

   // length of the running cycle and age of the last serial clock rise
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         busy_cnt_r <= 32'h0;
         rise_age_r <= 4'hF;
      end
      else
      begin
         busy_cnt_r <= prog_busy_out ? busy_cnt_r + 32'h1 : 32'h0;
         if ($rose(serial_clk_in))
            rise_age_r <= 4'h0;
         else if (rise_age_r != 4'hF)
            rise_age_r <= rise_age_r + 4'h1;
      end
   end

   // output timing properties
   property p_oe_release;
      $fell(chip_select_in) |-> ##[1:6] !serial_out_oe_out;
   endproperty
   property p_oe_deselected;
      !chip_select_in [*6] |-> !serial_out_oe_out;
   endproperty
   property p_oe_needs_select;
      $rose(serial_out_oe_out) |-> chip_select_in;
   endproperty
   property p_busy_low;
      serial_out_oe_out && prog_busy_out && $past(prog_busy_out, 2) |-> !serial_out_out;
   endproperty
   property p_ready_high;
      $fell(prog_busy_out) && serial_out_oe_out |-> ##[0:3] serial_out_out && serial_out_oe_out;
   endproperty
   property p_busy_bound;
      prog_busy_out |-> busy_cnt_r <= TWL_CYC;
   endproperty
   property p_start_on_fall;
      $rose(prog_busy_out) |-> !$past(chip_select_in, 2);
   endproperty
   property p_data_follows_clk;
      serial_out_oe_out && $past(serial_out_oe_out) && $changed(serial_out_out)
      && !prog_busy_out && !$past(prog_busy_out, 3) |-> rise_age_r <= 4'hA;
   endproperty

   a_oe_release: assert property (p_oe_release) else $error("output still on after deselect");
   a_oe_deselected: assert property (p_oe_deselected) else $error("output on while deselected");
   a_oe_needs_select: assert property (p_oe_needs_select) else $error("output on unselected");
   a_busy_low: assert property (p_busy_low) else $error("status high while busy");
   a_ready_high: assert property (p_ready_high) else $error("status not high when ready");
   a_busy_bound: assert property (p_busy_bound) else $error("programming cycle too long");
   a_start_on_fall: assert property (p_start_on_fall) else $error("cycle began while selected");
   a_data_follows_clk: assert property (p_data_follows_clk) else $error("data moved w/o clock");

   c_busy: cover property ($rose(prog_busy_out));
   c_ready: cover property ($fell(prog_busy_out) && serial_out_oe_out);
   c_read: cover property (serial_out_oe_out && !prog_busy_out && $rose(serial_clk_in));
endmodule
bind seecp_port seecp_sva #(.TWL_CYC(TWL_CYC)) u_sva (.clk_in(clk_in), .rstn_in(rstn_in),
   .chip_select_in(chip_select_in), .serial_clk_in(serial_clk_in),
   .serial_in_pin_in(serial_in_pin_in), .word_size_strap_in(word_size_strap_in),
   .serial_out_out(serial_out_out), .serial_out_oe_out(serial_out_oe_out),
   .prog_busy_out(prog_busy_out));
`default_nettype wire

/* File: bench/seecp_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the three-wire port; clock idles low outside frames
module seecp_host
(
   input  wire logic clk_in,
   input  wire logic sdo_in,
   input  wire logic sdo_oe_in,
   output logic      sel_out,
   output logic      sclk_out,
   output logic      sdi_out
);
   // idle pins at time zero
   initial
   begin
      sel_out = 1'b0;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
   end
   // wait whole system cycles, then step just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // one 80 ns serial clock, data set up while the clock is low
   task automatic pulse(input logic b);
      sdi_out = b;
      tick(4);
      sclk_out = 1'b1;
      tick(4);
      sclk_out = 1'b0;
   endtask
   // select and send n bits, msb first; leading zeros precede the start bit
   task automatic cmd(input logic [31:0] v, input int n);
      sel_out = 1'b1;
      tick(4);
      for (int i = n - 1; i >= 0; i--)
         pulse(v[i]);
   endtask
   // sample the output before each further clock; a released pin reads z
   task automatic shift(input int n, output logic [32:0] q);
      q = 33'h0;
      for (int i = 0; i < n; i++)
      begin
         if (i > 0)
            pulse(~sdi_out);
         tick(3);
         q = {q[31:0], sdo_oe_in ? sdo_in : 1'bz};
      end
   endtask
   // drop select and keep it low; data line does not keep its last value
   task automatic deselect();
      sel_out = 1'b0;
      sdi_out = ~sdi_out;
      tick(30);
   endtask
   // raise select alone to poll the status
   task automatic reselect();
      sel_out = 1'b1;
      tick(8);
   endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int TWC = 200;
   localparam int ERASE_ALL_TIME = 300;
   localparam int WRITE_ALL_TIME = 400;
   logic clk, rstn, sel, sclk, sdi, sdo, sdo_oe, busy, strap;
   int   mismatches;
   int   checks;

   seecp_port #(.HV_VARIANT(1'b0), .TWC_CYC(TWC), .TEC_CYC(ERASE_ALL_TIME), .TWL_CYC(WRITE_ALL_TIME)) dut (
      .clk_in(clk), .rstn_in(rstn), .chip_select_in(sel), .serial_clk_in(sclk),
      .serial_in_pin_in(sdi), .word_size_strap_in(strap), .serial_out_out(sdo),
      .serial_out_oe_out(sdo_oe), .prog_busy_out(busy));
   seecp_host host (.clk_in(clk), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .sel_out(sel),
      .sclk_out(sclk), .sdi_out(sdi));

   // 100 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare and count
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // one instruction; lim > 0 expects a programming cycle and polls it
   task automatic run(input logic [31:0] v, input int n, input int lim);
      int cyc;
      host.cmd(v, n);
      host.tick(6);
      check(sdo_oe, 1'b0);
      host.deselect();
      check(busy, lim > 0);
      if (lim > 0)
      begin
         host.reselect();
         check({sdo_oe, sdo}, 2'b10);
         cyc = 0;
         while (sdo !== 1'b1 && cyc < 1000)
         begin
            host.tick(1);
            cyc++;
         end
         check(cyc + 30 <= lim, 1'b1);
         check({sdo_oe, sdo}, 2'b11);
         host.deselect();
         check(sdo_oe, 1'b0);
      end
   endtask
   // read two sequential words after the dummy zero
   task automatic rd(input logic [31:0] v, input int n, input int w, input logic [31:0] exp);
      logic [32:0] q;
      host.cmd(v, n);
      host.shift(1 + 2 * w, q);
      host.deselect();
      check(q, {1'b0, exp});
   endtask
   // hang guard, about eight times the expected run
   initial
   begin
      repeat (40000) @(posedge clk);
      mismatches++;
      final_report();
   end
   // main sequence, 8-bit words first, then 16-bit
   initial
   begin
      rstn = 1'b0;
      strap = 1'b0;
      mismatches = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      host.tick(4);
      run({1'b1, 2'b01, 9'h005, 8'h3C}, 20, 0);
      run({1'b1, 2'b00, 2'b11, 7'h00}, 12, 0);
      run({1'b1, 2'b00, 2'b10, 7'h00}, 12, ERASE_ALL_TIME);
      rd({1'b1, 2'b10, 9'h004}, 15, 8, 32'hFFFF);
      run({1'b1, 2'b01, 9'h005, 8'h3C}, 20, TWC);
      rd({1'b1, 2'b10, 9'h004}, 12, 8, 32'hFF3C);
      run({1'b1, 2'b01, 9'h004, 8'hA5} >> 5, 15, 0);
      rd({1'b1, 2'b10, 9'h004}, 12, 8, 32'hFF3C);
      run({1'b1, 2'b00, 2'b00, 7'h00}, 12, 0);
      run({1'b1, 2'b11, 9'h004}, 12, 0);
      run({1'b1, 2'b00, 2'b11, 7'h00}, 12, 0);
      run({1'b1, 2'b00, 2'b01, 7'h00, 8'h96}, 20, WRITE_ALL_TIME);
      rd({1'b1, 2'b10, 9'h000}, 12, 8, 32'h9696);
      run({1'b1, 2'b11, 9'h001}, 12, TWC);
      rd({1'b1, 2'b10, 9'h000}, 12, 8, 32'h96FF);
      strap = 1'b1;
      host.tick(4);
      run({1'b1, 2'b01, 8'h03, 16'hA55A}, 27, TWC);
      rd({1'b1, 2'b10, 8'h03}, 11, 16, 32'hA55A9696);
      final_report();
   end
endmodule
`default_nettype wire
